/* inc/ata_multi_pkg.sv */
package ata_multi_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_LBA = 8'h08;
  localparam logic [7:0] OFS_FEATURE = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_ERROR = 8'h14;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_CONTROL = 8'h1C;

  // ----------------------------------------------------------------
  // Command and feature codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_MULTI = 8'hC4;
  localparam logic [7:0] CMD_WRITE_MULTI = 8'hC5;
  localparam logic [7:0] CMD_SET_MULTI = 8'hC6;
  localparam logic [7:0] CMD_READ_DMA = 8'hC8;
  localparam logic [7:0] CMD_READ_DMA_NR = 8'hC9;
  localparam logic [7:0] FEAT_KEEP = 8'h66;
  localparam logic [7:0] FEAT_REVERT = 8'hCC;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABRT = 2;
  localparam int CTL_SRST = 2;
  localparam int MODE_EN = 8;
  localparam int MODE_KEEP = 9;
  localparam logic [4:0] BLK_DEFAULT = 5'h10;
  localparam logic MULTI_EN_DEFAULT = 1'b1;
  localparam logic KEEP_DEFAULT = 1'b0;
  localparam logic [8:0] FULL_COUNT = 9'h100;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PREP = 3'b100,
    S_MEDIA = 3'b101,
    S_XFER = 3'b111,
    S_DONE = 3'b110,
    S_SETBLK = 3'b010
  } state_t;

  typedef struct packed {
    logic write;
    logic [27:0] lba;
  } media_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic corr;
  } media_rsp_t;

endpackage

/* logic/wb_port.sv */
`timescale 1ns/10ps
module wb_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] rd_data_i,
  output logic wr_o,
  output logic rd_o,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);

  logic take;

  // Ack drops the cycle after it is given, so one access per request
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_o = take & wb_we_i;
  assign rd_o = take & ~wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= take;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (rd_o)
    begin
      wb_dat_o <= rd_data_i;
    end
  end

endmodule

/* logic/blk_counter.sv */
`timescale 1ns/10ps
module blk_counter #(
  parameter int CW = 9,
  parameter int BW = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [CW-1:0] count_i,
  input wire logic blk_start_i,
  input wire logic [BW-1:0] blk_size_i,
  input wire logic step_i,
  output logic [CW-1:0] remaining_o,
  output logic [BW-1:0] blk_left_o,
  output logic [BW-1:0] blk_len_o
);

  // Last block is the remainder when fewer sectors are left
  function automatic logic [BW-1:0] clip(input logic [CW-1:0] rem, input logic [BW-1:0] sz);
    clip = (rem < CW'(sz)) ? rem[BW-1:0] : sz;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remaining_o <= '0;
    end
    else if (load_i)
    begin
      remaining_o <= count_i;
    end
    else if (step_i && remaining_o != '0)
    begin
      remaining_o <= remaining_o - CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      blk_left_o <= '0;
      blk_len_o <= '0;
    end
    else if (blk_start_i)
    begin
      blk_left_o <= clip(remaining_o, blk_size_i);
      blk_len_o <= clip(remaining_o, blk_size_i);
    end
    else if (step_i && blk_left_o != '0)
    begin
      blk_left_o <= blk_left_o - BW'(1);
    end
  end

endmodule

/* logic/ata_multi_ctrl.sv */
`timescale 1ns/10ps
module ata_multi_ctrl #(
  parameter int LBA_W = 28
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output ata_multi_pkg::media_req_t media_req_o,
  output logic media_req_valid_o,
  input wire ata_multi_pkg::media_rsp_t media_rsp_i,
  output logic dmarq_o,
  input wire logic dmack_i,
  output logic intrq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ata_multi_pkg::state_t state_q;
  logic wr;
  logic rd;
  logic [31:0] rd_data;
  logic [7:0] count_q;
  logic [LBA_W-1:0] lba_q;
  logic [7:0] feature_q;
  logic [7:0] cmd_q;
  logic [7:0] error_q;
  logic corr_q;
  logic multi_en_q;
  logic [4:0] blk_size_q;
  logic keep_q;
  logic intr_q;
  logic pend_q;
  logic blk_unc_q;
  logic [4:0] xfer_left_q;
  logic is_write;
  logic is_dma;
  logic bsy;
  logic drq;
  logic cmd_wr;
  logic srst;
  logic load;
  logic blk_start;
  logic step;
  logic rsp_ok;
  logic unc;
  logic sect_done;
  logic [8:0] remaining;
  logic [4:0] blk_left;
  logic [4:0] blk_len;

  function automatic logic size_ok(input logic [7:0] v);
    size_ok = (v == 8'h01) || (v == 8'h02) || (v == 8'h04) || (v == 8'h08) || (v == 8'h10);
  endfunction

  function automatic logic [31:0] lane_mix(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    lane_mix = r;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and decode
  // ----------------------------------------------------------------
  wb_port u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .rd_data_i(rd_data),
    .wr_o(wr),
    .rd_o(rd),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o)
  );

  assign is_write = (cmd_q == ata_multi_pkg::CMD_WRITE_MULTI);
  assign is_dma = (cmd_q == ata_multi_pkg::CMD_READ_DMA) ||
                  (cmd_q == ata_multi_pkg::CMD_READ_DMA_NR);
  // Command writes while busy are dropped, as on a real task file
  assign cmd_wr = wr && wb_adr_i == ata_multi_pkg::OFS_CMD && wb_sel_i[0] &&
                  state_q == ata_multi_pkg::S_IDLE;
  assign srst = wr && wb_adr_i == ata_multi_pkg::OFS_CONTROL && wb_sel_i[0] &&
                wb_dat_i[ata_multi_pkg::CTL_SRST];
  assign bsy = (state_q != ata_multi_pkg::S_IDLE) && (state_q != ata_multi_pkg::S_XFER);
  assign drq = (state_q == ata_multi_pkg::S_XFER);

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      ata_multi_pkg::OFS_COUNT: rd_data[7:0] = count_q;
      ata_multi_pkg::OFS_LBA: rd_data[LBA_W-1:0] = lba_q;
      ata_multi_pkg::OFS_FEATURE: rd_data[7:0] = feature_q;
      ata_multi_pkg::OFS_CMD:
      begin
        rd_data[ata_multi_pkg::ST_BSY] = bsy;
        rd_data[ata_multi_pkg::ST_DRDY] = ~bsy;
        rd_data[ata_multi_pkg::ST_DRQ] = drq;
        rd_data[ata_multi_pkg::ST_CORR] = corr_q;
        rd_data[ata_multi_pkg::ST_ERR] = |error_q;
      end
      ata_multi_pkg::OFS_ERROR: rd_data[7:0] = error_q;
      ata_multi_pkg::OFS_MODE:
      begin
        rd_data[4:0] = blk_size_q;
        rd_data[ata_multi_pkg::MODE_EN] = multi_en_q;
        rd_data[ata_multi_pkg::MODE_KEEP] = keep_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Sector and block counting
  // ----------------------------------------------------------------
  // zero count means 256
  assign load = cmd_wr;
  assign rsp_ok = media_rsp_i.done && pend_q && state_q == ata_multi_pkg::S_MEDIA;
  assign unc = media_rsp_i.err & ~media_rsp_i.corr;
  assign step = rsp_ok;
  // Reload at every host block end, writes too, or later write blocks never end
  assign blk_start = (state_q == ata_multi_pkg::S_PREP) ||
                     (state_q == ata_multi_pkg::S_XFER && sect_done && xfer_left_q == 5'h01);

  blk_counter #(
    .CW(9),
    .BW(5)
  ) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i | srst),
    .load_i(load),
    .count_i((count_q == 8'h00) ? ata_multi_pkg::FULL_COUNT : {1'b0, count_q}),
    .blk_start_i(blk_start),
    .blk_size_i(is_dma ? 5'h01 : blk_size_q),
    .step_i(step),
    .remaining_o(remaining),
    .blk_left_o(blk_left),
    .blk_len_o(blk_len)
  );

  // One sector moved between host and device
  always_comb
  begin
    sect_done = 1'b0;
    if (state_q == ata_multi_pkg::S_XFER)
    begin
      if (is_dma)
      begin
        sect_done = dmack_i & dmarq_o;
      end
      else
      begin
        sect_done = (wr | rd) && wb_adr_i == ata_multi_pkg::OFS_DATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      state_q <= ata_multi_pkg::S_IDLE;
    end
    else
    begin
      unique case (state_q)
        ata_multi_pkg::S_IDLE:
        begin
          if (cmd_wr)
          begin
            unique case (wb_dat_i[7:0])
              ata_multi_pkg::CMD_SET_MULTI: state_q <= ata_multi_pkg::S_SETBLK;
              ata_multi_pkg::CMD_READ_MULTI, ata_multi_pkg::CMD_WRITE_MULTI:
                state_q <= multi_en_q ? ata_multi_pkg::S_PREP : ata_multi_pkg::S_DONE;
              ata_multi_pkg::CMD_READ_DMA, ata_multi_pkg::CMD_READ_DMA_NR:
                state_q <= ata_multi_pkg::S_PREP;
              default: state_q <= ata_multi_pkg::S_DONE;
            endcase
          end
        end
        ata_multi_pkg::S_PREP:
          state_q <= is_write ? ata_multi_pkg::S_XFER : ata_multi_pkg::S_MEDIA;
        ata_multi_pkg::S_MEDIA:
        begin
          if (rsp_ok)
          begin
            if (is_dma)
            begin
              state_q <= unc ? ata_multi_pkg::S_DONE : ata_multi_pkg::S_XFER;
            end
            else if (is_write)
            begin
              if (unc || (blk_left == 5'h01 && remaining == 9'h001))
              begin
                state_q <= ata_multi_pkg::S_DONE;
              end
              else if (blk_left == 5'h01)
              begin
                state_q <= ata_multi_pkg::S_XFER;
              end
            end
            else if (blk_left == 5'h01)
            begin
              state_q <= ata_multi_pkg::S_XFER;
            end
          end
        end
        ata_multi_pkg::S_XFER:
        begin
          if (sect_done && xfer_left_q == 5'h01)
          begin
            if (is_write)
            begin
              state_q <= ata_multi_pkg::S_MEDIA;
            end
            else if (blk_unc_q || remaining == 9'h000)
            begin
              state_q <= ata_multi_pkg::S_DONE;
            end
            else
            begin
              state_q <= ata_multi_pkg::S_MEDIA;
            end
          end
        end
        ata_multi_pkg::S_SETBLK: state_q <= ata_multi_pkg::S_DONE;
        ata_multi_pkg::S_DONE: state_q <= ata_multi_pkg::S_IDLE;
        default: state_q <= ata_multi_pkg::S_IDLE;
      endcase
    end
  end

  // Host sectors left in the current block
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      xfer_left_q <= 5'h00;
    end
    else if (state_q == ata_multi_pkg::S_PREP && is_write)
    begin
      xfer_left_q <= (remaining < 9'(blk_size_q)) ? remaining[4:0] : blk_size_q;
    end
    else if (state_q == ata_multi_pkg::S_MEDIA && rsp_ok && blk_left == 5'h01)
    begin
      xfer_left_q <= is_write ? ((remaining - 9'h001 < 9'(blk_size_q)) ?
                     5'(remaining - 9'h001) : blk_size_q) : blk_len;
    end
    else if (sect_done)
    begin
      xfer_left_q <= xfer_left_q - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Media requests and address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      pend_q <= 1'b0;
      media_req_valid_o <= 1'b0;
      media_req_o <= '0;
    end
    else
    begin
      media_req_valid_o <= 1'b0;
      if (state_q == ata_multi_pkg::S_MEDIA && !pend_q && !rsp_ok)
      begin
        pend_q <= 1'b1;
        media_req_valid_o <= 1'b1;
        media_req_o.write <= is_write;
        media_req_o.lba <= lba_q;
      end
      else if (rsp_ok)
      begin
        pend_q <= 1'b0;
      end
    end
  end

  // Uncorrectable errors freeze the address; the last sector is never passed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lba_q <= '0;
    end
    else if (wr && wb_adr_i == ata_multi_pkg::OFS_LBA && state_q == ata_multi_pkg::S_IDLE)
    begin
      lba_q <= LBA_W'(lane_mix(32'(lba_q), wb_dat_i, wb_sel_i));
    end
    else if (rsp_ok && !unc && remaining != 9'h001)
    begin
      lba_q <= lba_q + LBA_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= 8'h00;
    end
    else if (wr && wb_adr_i == ata_multi_pkg::OFS_COUNT && wb_sel_i[0] &&
             state_q == ata_multi_pkg::S_IDLE)
    begin
      count_q <= wb_dat_i[7:0];
    end
    else if (state_q == ata_multi_pkg::S_DONE && (is_dma || cmd_q == ata_multi_pkg::CMD_READ_MULTI
             || is_write) && error_q == 8'h00)
    begin
      count_q <= 8'h00;
    end
  end

  // Feature writes also pick the soft reset policy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      feature_q <= 8'h00;
      keep_q <= ata_multi_pkg::KEEP_DEFAULT;
    end
    else if (wr && wb_adr_i == ata_multi_pkg::OFS_FEATURE && wb_sel_i[0] &&
             state_q == ata_multi_pkg::S_IDLE)
    begin
      feature_q <= wb_dat_i[7:0];
      if (wb_dat_i[7:0] == ata_multi_pkg::FEAT_KEEP)
      begin
        keep_q <= 1'b1;
      end
      else if (wb_dat_i[7:0] == ata_multi_pkg::FEAT_REVERT)
      begin
        keep_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiple mode settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      multi_en_q <= ata_multi_pkg::MULTI_EN_DEFAULT;
      blk_size_q <= ata_multi_pkg::BLK_DEFAULT;
    end
    else if (srst && !keep_q)
    begin
      multi_en_q <= ata_multi_pkg::MULTI_EN_DEFAULT;
      blk_size_q <= ata_multi_pkg::BLK_DEFAULT;
    end
    else if (state_q == ata_multi_pkg::S_SETBLK)
    begin
      if (count_q != 8'h00 && size_ok(count_q))
      begin
        multi_en_q <= 1'b1;
        blk_size_q <= count_q[4:0];
      end
      else
      begin
        multi_en_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command register, errors and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      cmd_q <= 8'h00;
      error_q <= 8'h00;
      corr_q <= 1'b0;
      blk_unc_q <= 1'b0;
    end
    else if (cmd_wr)
    begin
      cmd_q <= wb_dat_i[7:0];
      error_q <= 8'h00;
      corr_q <= 1'b0;
      blk_unc_q <= 1'b0;
      if (!multi_en_q && (wb_dat_i[7:0] == ata_multi_pkg::CMD_READ_MULTI ||
          wb_dat_i[7:0] == ata_multi_pkg::CMD_WRITE_MULTI))
      begin
        error_q[ata_multi_pkg::ER_ABRT] <= 1'b1;
      end
      else if (wb_dat_i[7:0] != ata_multi_pkg::CMD_READ_MULTI &&
               wb_dat_i[7:0] != ata_multi_pkg::CMD_WRITE_MULTI &&
               wb_dat_i[7:0] != ata_multi_pkg::CMD_SET_MULTI &&
               wb_dat_i[7:0] != ata_multi_pkg::CMD_READ_DMA &&
               wb_dat_i[7:0] != ata_multi_pkg::CMD_READ_DMA_NR)
      begin
        error_q[ata_multi_pkg::ER_ABRT] <= 1'b1;
      end
    end
    else if (state_q == ata_multi_pkg::S_SETBLK && count_q != 8'h00 && !size_ok(count_q))
    begin
      error_q[ata_multi_pkg::ER_ABRT] <= 1'b1;
    end
    else if (rsp_ok)
    begin
      error_q[ata_multi_pkg::ER_UNC] <= error_q[ata_multi_pkg::ER_UNC] | unc;
      corr_q <= corr_q | media_rsp_i.corr;
      blk_unc_q <= blk_unc_q | unc;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      dmarq_o <= 1'b0;
    end
    else
    begin
      dmarq_o <= (state_q == ata_multi_pkg::S_XFER) && is_dma && !sect_done;
    end
  end

  // Event set wins over a status read in the same cycle
  always_comb
  begin
    intr_q = 1'b0;
    if (state_q == ata_multi_pkg::S_MEDIA && rsp_ok && blk_left == 5'h01)
    begin
      intr_q = !is_dma && !is_write;
      if (is_write && !unc && remaining != 9'h001)
      begin
        intr_q = 1'b1;
      end
    end
    // single DMA interrupt
    // Aborts interrupt too; only a read multiple that ran ends silently
    if (state_q == ata_multi_pkg::S_DONE && (is_dma || is_write ||
        error_q[ata_multi_pkg::ER_ABRT] || cmd_q != ata_multi_pkg::CMD_READ_MULTI))
    begin
      intr_q = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      intrq_o <= 1'b0;
    end
    else if (intr_q)
    begin
      intrq_o <= 1'b1;
    end
    else if ((rd && wb_adr_i == ata_multi_pkg::OFS_CMD) || cmd_wr)
    begin
      intrq_o <= 1'b0;
    end
  end

endmodule

/* sim/ata_multi_ctrl_asserts.sv */
`timescale 1ns/10ps
module ata_multi_ctrl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic media_req_valid_o,
  input wire logic dmarq_o,
  input wire logic dmack_i,
  input wire logic intrq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stat_rd;
    s_req ##0 !wb_we_i && wb_adr_i == ata_multi_pkg::OFS_CMD;
  endsequence
  property p_ack_lat;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_unmapped;
    s_req ##0 !wb_we_i && wb_adr_i[7:5] != 3'h0 |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_req_pulse;
    media_req_valid_o |=> !media_req_valid_o;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("media request not a pulse");
  property p_dmarq_hold;
    dmarq_o && !dmack_i |=> dmarq_o;
  endproperty
  a_dmarq_hold: assert property (p_dmarq_hold) else $error("dma request dropped");
  property p_dmarq_drop;
    dmarq_o && dmack_i |=> !dmarq_o;
  endproperty
  a_dmarq_drop: assert property (p_dmarq_drop) else $error("dma request stuck");
  property p_dma_quiet;
    dmarq_o |-> !intrq_o;
  endproperty
  a_dma_quiet: assert property (p_dma_quiet) else $error("interrupt during dma");
  property p_dma_busy;
    dmarq_o ##0 s_stat_rd |=> wb_dat_o[ata_multi_pkg::ST_BSY] || wb_dat_o[ata_multi_pkg::ST_DRQ];
  endproperty
  a_dma_busy: assert property (p_dma_busy) else $error("dma phase idle status");
endmodule

bind ata_multi_ctrl ata_multi_ctrl_asserts ata_multi_ctrl_asserts_i (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .media_req_valid_o(media_req_valid_o), .dmarq_o(dmarq_o), .dmack_i(dmack_i),
  .intrq_o(intrq_o));

/* sim/media_dma_model.sv */
`timescale 1ns/10ps
module media_dma_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ata_multi_pkg::media_req_t media_req_i,
  input wire logic media_req_valid_i,
  input wire logic dmarq_i,
  input wire logic [27:0] bad_lba_i,
  input wire logic bad_en_i,
  input wire logic bad_corr_i,
  output ata_multi_pkg::media_rsp_t media_rsp_o,
  output logic dmack_o
);
  logic [3:0] wait_q;
  logic [27:0] lba_q;
  logic [2:0] dma_q;
  logic hit;
  assign hit = bad_en_i && lba_q == bad_lba_i;
  // Odd sectors answer slowly
  always_ff @(posedge clk_i)
  begin
    media_rsp_o <= '0;
    if (rst_i)
      wait_q <= 4'h0;
    else if (media_req_valid_i)
    begin
      wait_q <= media_req_i.lba[0] ? 4'h6 : 4'h1;
      lba_q <= media_req_i.lba;
    end
    else if (wait_q != 4'h0)
    begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1)
        media_rsp_o <= '{1'b1, hit, hit && bad_corr_i};
    end
  end
  always_ff @(posedge clk_i)
  begin
    dmack_o <= 1'b0;
    if (rst_i || !dmarq_i || dmack_o)
      dma_q <= 3'h0;
    else if (dma_q == 3'h5)
      dmack_o <= 1'b1;
    else
      dma_q <= dma_q + 3'h1;
  end
endmodule

/* sim/ata_multi_ctrl_tb_top.sv */
`timescale 1ns/10ps
module ata_multi_ctrl_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, bad_en = 1'b0, bad_corr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [27:0] bad_lba = 28'h0;
  logic ack, mval, dmarq, dmack, intrq;
  logic [31:0] rdat, q;
  ata_multi_pkg::media_req_t mreq;
  ata_multi_pkg::media_rsp_t mrsp;
  int err_total = 0, check_count = 0, cycles = 0;
  int vals[] = '{0, 3, 1, 2, 4, 8, 16, 17, 2};
  ata_multi_ctrl ata_multi_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .media_req_o(mreq), .media_req_valid_o(mval), .media_rsp_i(mrsp),
    .dmarq_o(dmarq), .dmack_i(dmack), .intrq_o(intrq));
  media_dma_model media_dma_model_i (.clk_i(clk_i), .rst_i(rst_i), .media_req_i(mreq),
    .media_req_valid_i(mval), .dmarq_i(dmarq), .bad_lba_i(bad_lba), .bad_en_i(bad_en),
    .bad_corr_i(bad_corr), .media_rsp_o(mrsp), .dmack_o(dmack));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // ------------------------------
  // Bus and checking helpers
  // ------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask
  // Held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_intr();
    while (intrq !== 1'b1)
      @(posedge clk_i);
  endtask
  task automatic issue(input logic [7:0] c, input logic [31:0] n, input logic [31:0] l);
    bus(1'b1, ata_multi_pkg::OFS_COUNT, n);
    bus(1'b1, ata_multi_pkg::OFS_LBA, l);
    bus(1'b1, ata_multi_pkg::OFS_CMD, {24'h0, c});
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic set_blk(input logic [31:0] v);
    logic en;
    en = v inside {1, 2, 4, 8, 16};
    issue(ata_multi_pkg::CMD_SET_MULTI, v, 32'h0);
    wait_intr();
    bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
    bus(1'b0, ata_multi_pkg::OFS_ERROR, 32'h0);
    chk("abort", q[ata_multi_pkg::ER_ABRT], !en && v != 0);
    bus(1'b0, ata_multi_pkg::OFS_MODE, 32'h0);
    chk("mode", q & 32'h11F, {23'h0, en, 3'h0, en ? v[4:0] : q[4:0]});
  endtask
  task automatic xfer(input logic [7:0] c, input int cnt, input int nblk, input int eb,
                      input logic [31:0] st_end);
    int left;
    int len;
    logic wr;
    left = cnt;
    wr = c == ata_multi_pkg::CMD_WRITE_MULTI;
    issue(c, cnt, 32'h100);
    for (int b = 0; b < nblk; b++)
    begin
      len = left < 2 ? left : 2;
      if (wr && b == 0)
      begin
        repeat (4) @(posedge clk_i);
        chk("first_intr", intrq, 0);
      end
      else
        wait_intr();
      bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
      chk("blk_drq", q[ata_multi_pkg::ST_DRQ], 1);
      chk("blk_err", q[ata_multi_pkg::ST_ERR], b >= eb);
      repeat (len) bus(wr, ata_multi_pkg::OFS_DATA, 32'h0);
      left = left - len;
    end
    if (wr)
      wait_intr();
    repeat (40) @(posedge clk_i);
    if (!wr)
      chk("end_intr", intrq, 0);
    bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
    chk("end_status", q & 32'h89, st_end);
  endtask
  task automatic dma(input logic [7:0] c, input logic [31:0] l_end, input logic e);
    issue(c, 32'h3, 32'h200);
    while (dmarq !== 1'b1)
      @(posedge clk_i);
    bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
    chk("dma_busy", q[ata_multi_pkg::ST_BSY] | q[ata_multi_pkg::ST_DRQ], 1);
    wait_intr();
    bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
    chk("dma_err", q[ata_multi_pkg::ST_ERR], e);
    repeat (40) @(posedge clk_i);
    chk("dma_intr", intrq, 0);
    bus(1'b0, ata_multi_pkg::OFS_LBA, 32'h0);
    chk("dma_lba", q & 32'hFFFFFFF, l_end);
  endtask
  task automatic soft_rst(input logic [7:0] f, input logic [31:0] sz);
    bus(1'b1, ata_multi_pkg::OFS_FEATURE, {24'h0, f});
    bus(1'b1, ata_multi_pkg::OFS_CONTROL, 32'h4);
    repeat (4) @(posedge clk_i);
    bus(1'b0, ata_multi_pkg::OFS_MODE, 32'h0);
    chk("srst_mode", q & 32'h11F, 32'h100 | sz);
  endtask
  task automatic refused(input logic [7:0] c);
    issue(c, 32'h1, 32'h0);
    wait_intr();
    bus(1'b0, ata_multi_pkg::OFS_CMD, 32'h0);
    bus(1'b0, ata_multi_pkg::OFS_ERROR, 32'h0);
    chk("refused", q[ata_multi_pkg::ER_ABRT], 1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ata_multi_pkg::OFS_MODE, 32'h0);
    chk("reset_mode", q & 32'h31F, 32'h110);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    foreach (vals[i])
      set_blk(vals[i]);
    xfer(ata_multi_pkg::CMD_READ_MULTI, 5, 3, 99, 32'h0);
    xfer(ata_multi_pkg::CMD_WRITE_MULTI, 5, 3, 99, 32'h0);
    bad_lba <= 28'h101;
    bad_en <= 1'b1;
    // no task register checks after an error block
    xfer(ata_multi_pkg::CMD_READ_MULTI, 4, 1, 0, 32'h1);
    xfer(ata_multi_pkg::CMD_WRITE_MULTI, 4, 1, 99, 32'h1);
    bad_corr <= 1'b1;
    xfer(ata_multi_pkg::CMD_READ_MULTI, 4, 2, 99, 32'h0);
    bad_en <= 1'b0;
    bad_corr <= 1'b0;
    dma(ata_multi_pkg::CMD_READ_DMA, 32'h202, 1'b0);
    bad_lba <= 28'h201;
    bad_en <= 1'b1;
    dma(ata_multi_pkg::CMD_READ_DMA_NR, 32'h201, 1'b1);
    bad_en <= 1'b0;
    soft_rst(ata_multi_pkg::FEAT_KEEP, 32'h2);
    soft_rst(ata_multi_pkg::FEAT_REVERT, 32'h10);
    set_blk(0);
    refused(ata_multi_pkg::CMD_READ_MULTI);
    refused(ata_multi_pkg::CMD_WRITE_MULTI);
    test_done();
  end
endmodule
